// ### core/fesq_pkg.sv
// constants shared by the flash command controller and its bus strobe engine
// assumes a 40 MHz clock and an 8-bit parallel flash with async strobes
package fesq_pkg;
   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_PERIOD_NS   = 25;
   localparam int LOAD_WINDOW_US  = 50;                                      // sector load window
   localparam int LOAD_WINDOW_CYC = (LOAD_WINDOW_US * 1000) / CLK_PERIOD_NS; // longest, round down
   localparam int SUSPEND_MAX_US  = 20;
   localparam int SUSPEND_MAX_CYC = (SUSPEND_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int STROBE_LOW_NS   = 100;                                     // write/read pulse width
   localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_GAP_NS   = 50;
   localparam int STROBE_GAP_CYC  = (STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_NS  = 500;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ************************************************************
   // command table values
   // ************************************************************
   localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
   localparam logic [19:0] UNLOCK_ADDR2 = 20'h002AA;
   localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
   localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
   localparam logic [7:0]  CMD_RESUME   = 8'h30;
   localparam logic [7:0]  CMD_PROG_SETUP = 8'hA0;
   localparam logic [7:0]  CMD_RESET    = 8'hF0;
   // ************************************************************
   // status bit positions on the data bus
   // ************************************************************
   localparam int DATA_POLL_POS    = 7;
   localparam int TOGGLE_POS       = 6;
   localparam int TIMEOUT_POS      = 5;
   localparam int SECTOR_TOG_POS   = 2;
   // ************************************************************
   // host-side control register map (word offsets on the plain port)
   // ************************************************************
   localparam logic [3:0] REG_CMD     = 4'h0;  // write: op code in [2:0]
   localparam logic [3:0] REG_ADDR    = 4'h1;  // flash address [19:0]
   localparam logic [3:0] REG_DATA    = 4'h2;  // program data [7:0]
   localparam logic [3:0] REG_STATUS  = 4'h3;  // read only
   localparam logic [3:0] REG_RDDATA  = 4'h4;  // last byte read from flash
   localparam logic [2:0] OP_PROGRAM  = 3'h1;
   localparam logic [2:0] OP_ERASE    = 3'h2;  // first sector
   localparam logic [2:0] OP_ADD_SECT = 3'h3;  // another sector in window
   localparam logic [2:0] OP_SUSPEND  = 3'h4;
   localparam logic [2:0] OP_RESUME   = 3'h5;
   localparam logic [2:0] OP_ABORT    = 3'h6;  // reset command byte
   localparam logic [2:0] OP_HWRESET  = 3'h7;  // pulse reset pin
   localparam logic [31:0] RST_ZERO   = 32'h00000000;
endpackage

// ### core/fesq_bus_cycle.sv
// one asynchronous flash bus cycle: write or read with chip select and strobes
// assumes the flash samples address on falling and data on rising write edge
`timescale 1ns/100ps
module fesq_bus_cycle
   import fesq_pkg::*;
(
   input  wire logic        i_clock,     // 40 MHz
   input  wire logic        i_rst,       // sync, active high
   input  wire logic        i_start,     // pulse: begin a cycle
   input  wire logic        i_write,     // 1 write, 0 read
   input  wire logic [19:0] i_addr,      // flash address
   input  wire logic [7:0]  i_wdata,     // write byte
   input  wire logic [7:0]  i_dq_in,     // data pins in
   output logic             o_busy,      // cycle under way
   output logic             o_done,      // pulse: cycle finished
   output logic [7:0]       o_rdata,     // byte read
   output logic [19:0]      o_addr,      // address pins
   output logic [7:0]       o_dq_out,    // data pins out
   output logic             o_dq_oe,     // drive data pins
   output logic             o_ce_n,      // chip select
   output logic             o_we_n,      // write strobe
   output logic             o_oe_n       // output enable
);
   // ************************************************************
   // timing counter
   // ************************************************************
   logic [3:0] cnt;
   logic [1:0] phase;       // 0 idle 1 low 2 gap
   wire        low_end = (phase == 2'd1) && (cnt == 4'(STROBE_LOW_CYC - 1));
   wire        gap_end = (phase == 2'd2) && (cnt == 4'(STROBE_GAP_CYC - 1));

   // address, data and falling strobes are all set on the same edge; strobes rise before data leaves
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         phase <= 2'd0; cnt <= 4'h0; o_busy <= 1'b0; o_done <= 1'b0;
         o_rdata <= 8'h00; o_addr <= 20'h00000; o_dq_out <= 8'h00; o_dq_oe <= 1'b0;
         o_ce_n <= 1'b1; o_we_n <= 1'b1; o_oe_n <= 1'b1;
      end else begin
         o_done <= 1'b0;
         cnt    <= cnt + 4'h1;
         if (phase == 2'd0 && i_start) begin
            phase <= 2'd1; cnt <= 4'h0; o_busy <= 1'b1;
            o_addr <= i_addr; o_dq_out <= i_wdata; o_dq_oe <= i_write;
            o_ce_n <= 1'b0; o_we_n <= !i_write; o_oe_n <= i_write;
         end else if (low_end) begin
            phase <= 2'd2; cnt <= 4'h0;
            o_ce_n <= 1'b1; o_we_n <= 1'b1; o_oe_n <= 1'b1;
            o_rdata <= i_dq_in;   // sampled just before the strobe rises
         end else if (gap_end) begin
            phase <= 2'd0; o_busy <= 1'b0; o_done <= 1'b1; o_dq_oe <= 1'b0;
         end
      end
   end
endmodule

// ### core/fesq_ctrl.sv
// host-side controller that drives a parallel NOR flash through its pins
// assumes a software master on a plain register port and one 40 MHz clock
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - erase is six writes, 80H then 30H
// - extra sectors within 50us else erase starts
// - program is four writes, last has data
// - hardware reset aborts, reissue program afterwards
// - read full byte only after toggle stops
// - reset byte after an erase failure returns read mode
module fesq_ctrl
   import fesq_pkg::*;
(
   input  wire logic        i_clock,       // 40 MHz
   input  wire logic        i_rst,         // sync, active high
   input  wire logic [3:0]  i_reg_addr,    // register index
   input  wire logic [31:0] i_reg_wdata,   // write data
   input  wire logic        i_reg_wr,      // write strobe
   input  wire logic        i_reg_rd,      // read strobe
   output logic [31:0]      o_reg_rdata,   // read data, one cycle later
   input  wire logic [7:0]  i_dq_in,       // flash data pins in
   input  wire logic        i_ready_busy_n,// shared pulled-up line level
   output logic [19:0]      o_addr,        // flash address
   output logic [7:0]       o_dq_out,      // flash data out
   output logic             o_dq_oe,       // drive flash data
   output logic             o_ce_n,        // chip select
   output logic             o_we_n,        // write strobe
   output logic             o_oe_n,        // output enable
   output logic             o_reset_n      // flash hardware reset
);
   typedef enum logic [3:0] {
      FS_IDLE   = 4'b0000,
      FS_SEQ    = 4'b0001,   // issuing command writes
      FS_WINDOW = 4'b0010,   // sector load window open
      FS_POLL   = 4'b0011,   // polling read pair
      FS_SUSP   = 4'b0100,   // waiting for suspend to settle
      FS_FINAL  = 4'b0101,   // extra read for settled byte
      FS_HWRST  = 4'b0110
   } fesq_state_t;

   // ************************************************************
   // state and registers
   // ************************************************************
   fesq_state_t state, next_state;
   logic [19:0] op_addr, cyc_addr, o_addr_w;             // operation, cycle and pin addresses
   logic [7:0]  op_data, last_byte, cyc_wdata, cyc_rdata, o_dq_out_w;
   logic [2:0]  op_kind, seq_idx, seq_len;               // operation, write index, length
   logic [15:0] tmr;
   logic        prev_toggle, first_poll;
   logic        suspended, erasing;                      // host view of the erase
   logic        done_ok, failed, refused;
   logic        cyc_start, cyc_write, cyc_busy, cyc_done, cyc_wr_q; // wr_q: last cycle wrote
   logic        o_ce_n_w, o_we_n_w, o_oe_n_w, o_dq_oe_w;

   // ************************************************************
   // command sequence tables
   // ************************************************************
   // address of write k of the current sequence; unlock pairs follow a fixed table
   function automatic logic [19:0] seq_addr(input logic [2:0] kind, input logic [2:0] k,
                                            input logic [19:0] a);
      if (kind == OP_PROGRAM)
         seq_addr = (k == 3'd1) ? UNLOCK_ADDR2 : (k == 3'd3) ? a : UNLOCK_ADDR1;
      else if (kind == OP_ERASE)
         seq_addr = (k == 3'd1 || k == 3'd4) ? UNLOCK_ADDR2 :
                    (k == 3'd5) ? a : UNLOCK_ADDR1;
      else
         seq_addr = a;
   endfunction

   function automatic logic [7:0] seq_data(input logic [2:0] kind, input logic [2:0] k,
                                           input logic [7:0] d);
      logic [7:0] unl;
      unl = (k[0] == 1'b0) ? UNLOCK_DATA1 : UNLOCK_DATA2;
      case (kind)
         OP_PROGRAM: seq_data = (k == 3'd2) ? CMD_PROG_SETUP : (k == 3'd3) ? d : unl;
         OP_ERASE: begin
            if (k == 3'd2)      seq_data = CMD_ERASE_SETUP;
            else if (k == 3'd5) seq_data = CMD_SECTOR_ERASE;
            else if (k < 3'd2)  seq_data = unl;
            else                seq_data = (k == 3'd3) ? UNLOCK_DATA1 : UNLOCK_DATA2;
         end
         OP_ADD_SECT: seq_data = CMD_SECTOR_ERASE;
         OP_SUSPEND:  seq_data = CMD_SUSPEND;
         OP_RESUME:   seq_data = CMD_RESUME;
         default:     seq_data = CMD_RESET;
      endcase
   endfunction

   // ************************************************************
   // decode of software orders
   // ************************************************************
   wire       cmd_wr   = i_reg_wr && (i_reg_addr == REG_CMD);
   wire [2:0] cmd_op   = i_reg_wdata[2:0];
   wire       in_prog  = (state != FS_IDLE) && (op_kind == OP_PROGRAM);
   // suspend is meaningful only while an erase runs; resume only when suspended
   wire       ok_susp  = erasing && !suspended && (state == FS_POLL || state == FS_WINDOW);
   wire       ok_res   = suspended && (state == FS_IDLE);
   wire       ok_add   = (state == FS_WINDOW);
   wire       ok_prog  = (state == FS_IDLE);
   wire       ok_erase = (state == FS_IDLE) && !suspended;
   wire       accept   = cmd_wr && ((cmd_op == OP_HWRESET) || (!in_prog && (
                         (cmd_op == OP_PROGRAM && ok_prog) || (cmd_op == OP_ERASE && ok_erase) ||
                         (cmd_op == OP_ADD_SECT && ok_add) || (cmd_op == OP_SUSPEND && ok_susp) ||
                         (cmd_op == OP_RESUME && ok_res) ||
                         (cmd_op == OP_ABORT && (failed || state == FS_IDLE)))));
   wire [2:0] seq_n    = (cmd_op == OP_PROGRAM) ? 3'd4 : (cmd_op == OP_ERASE) ? 3'd6 : 3'd1;
   wire       win_out  = (state == FS_WINDOW) && (tmr == 16'(LOAD_WINDOW_CYC - 5));    // margin
   wire       tog_now  = cyc_rdata[TOGGLE_POS];
   wire       stopped  = !first_poll && (tog_now == prev_toggle);
   wire       tmo_now  = cyc_rdata[TIMEOUT_POS];
   wire       seq_done = cyc_done && cyc_wr_q;    // a poll read still in flight is no write

   // ************************************************************
   // state transitions
   // ************************************************************
   always_comb begin
      next_state = state;
      case (state)
         FS_IDLE:   if (accept) next_state = (cmd_op == OP_HWRESET) ? FS_HWRST : FS_SEQ;
         FS_SEQ:    if (seq_done && seq_idx == seq_len - 3'd1)
                       next_state = (op_kind == OP_ERASE || op_kind == OP_ADD_SECT) ? FS_WINDOW :
                                    (op_kind == OP_SUSPEND) ? FS_SUSP :
                                    (op_kind == OP_ABORT) ? FS_IDLE : FS_POLL;
         FS_WINDOW: if (accept) next_state = (cmd_op == OP_HWRESET) ? FS_HWRST : FS_SEQ;
                    else if (win_out) next_state = FS_POLL;
         FS_POLL:   if (accept)
                       next_state = (cmd_op == OP_HWRESET) ? FS_HWRST : FS_SEQ;
                    else if (cyc_done && stopped) next_state = FS_FINAL;
         FS_SUSP:   if (tmr == 16'(SUSPEND_MAX_CYC)) next_state = FS_IDLE;
         FS_FINAL:  if (cyc_done) next_state = FS_IDLE;
         FS_HWRST:  if (tmr == 16'(RESET_PULSE_CYC)) next_state = FS_IDLE;
         default:   next_state = FS_IDLE;
      endcase
      if (accept && cmd_op == OP_HWRESET) next_state = FS_HWRST;
   end

   // bus cycle requests: writes while sequencing, reads back to back while polling
   assign cyc_start = !cyc_busy && !cyc_done &&
                      (state == FS_SEQ || state == FS_POLL || state == FS_FINAL);
   assign cyc_write = (state == FS_SEQ);
   assign cyc_addr  = (state == FS_SEQ) ? seq_addr(op_kind, seq_idx, op_addr) : op_addr;
   assign cyc_wdata = seq_data(op_kind, seq_idx, op_data);

   // ************************************************************
   // sequencing registers
   // ************************************************************
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= FS_IDLE; op_kind <= 3'h0; seq_idx <= 3'h0; seq_len <= 3'h1;
         tmr <= 16'h0000; prev_toggle <= 1'b0; first_poll <= 1'b1;
         suspended <= 1'b0; erasing <= 1'b0; cyc_wr_q <= 1'b0;
      end else begin
         state <= next_state;
         tmr   <= (next_state != state) ? 16'h0000 : tmr + 16'h0001;
         if (state == FS_WINDOW && cyc_done) tmr <= 16'h0000;   // window counts from cycle end, after the gap
         if (accept) begin
            op_kind <= cmd_op; seq_idx <= 3'h0; seq_len <= seq_n; first_poll <= 1'b1;
            if (cmd_op == OP_RESUME) suspended <= 1'b0;
            if (cmd_op == OP_HWRESET || cmd_op == OP_ABORT) begin
               suspended <= 1'b0; erasing <= 1'b0;
            end
            if (cmd_op == OP_ERASE) erasing <= 1'b1;
         end else if (state == FS_SEQ && seq_done) begin
            seq_idx <= seq_idx + 3'd1;
            if (op_kind == OP_RESUME) op_kind <= OP_ERASE;
         end
         if (cyc_start) cyc_wr_q <= cyc_write;
         if (state == FS_POLL && cyc_done) begin
            prev_toggle <= tog_now; first_poll <= 1'b0;
         end
         if (state == FS_SUSP && next_state == FS_IDLE) suspended <= 1'b1;
         if (state == FS_FINAL && cyc_done && op_kind != OP_PROGRAM) erasing <= 1'b0;
      end
   end

   // completion reporting; a new order clears done and refused, only abort or hardware reset clears failed, and a finish in that cycle wins
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         done_ok <= 1'b0; failed <= 1'b0; refused <= 1'b0; last_byte <= 8'h00;
      end else begin
         if (accept) begin
            done_ok <= 1'b0; refused <= 1'b0;
         end
         if (accept && (cmd_op == OP_ABORT || cmd_op == OP_HWRESET)) failed <= 1'b0;
         if (cmd_wr && !accept) refused <= 1'b1;
         if (state == FS_POLL && cyc_done && !stopped && !first_poll && tmo_now)
            failed <= 1'b1;
         if (state == FS_FINAL && cyc_done) begin
            done_ok <= 1'b1; last_byte <= cyc_rdata;
         end
      end
   end

   // ************************************************************
   // register port
   // ************************************************************
   wire [31:0] status_word = {21'h000000, i_ready_busy_n, erasing, suspended,
                              refused, failed, done_ok, state != FS_IDLE, state};
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_reg_rdata <= RST_ZERO; op_addr <= 20'h00000; op_data <= 8'hFF;
      end else begin
         if (i_reg_wr && i_reg_addr == REG_ADDR && !in_prog) op_addr <= i_reg_wdata[19:0];
         if (i_reg_wr && i_reg_addr == REG_DATA && !in_prog) op_data <= i_reg_wdata[7:0];
         if (!i_reg_rd)                    o_reg_rdata <= RST_ZERO;
         else if (i_reg_addr == REG_STATUS) o_reg_rdata <= status_word;
         else if (i_reg_addr == REG_ADDR)  o_reg_rdata <= {12'h000, op_addr};
         else if (i_reg_addr == REG_DATA)  o_reg_rdata <= {24'h000000, op_data};
         else if (i_reg_addr == REG_RDDATA) o_reg_rdata <= {24'h000000, last_byte};
         else                              o_reg_rdata <= RST_ZERO;
      end
   end

   // ************************************************************
   // pins
   // ************************************************************
   fesq_bus_cycle u_cycle (
      .i_clock  (i_clock),
      .i_rst    (i_rst),
      .i_start  (cyc_start),
      .i_write  (cyc_write),
      .i_addr   (cyc_addr),
      .i_wdata  (cyc_wdata),
      .i_dq_in  (i_dq_in),
      .o_busy   (cyc_busy),
      .o_done   (cyc_done),
      .o_rdata  (cyc_rdata),
      .o_addr   (o_addr_w),
      .o_dq_out (o_dq_out_w),
      .o_dq_oe  (o_dq_oe_w),
      .o_ce_n   (o_ce_n_w),
      .o_we_n   (o_we_n_w),
      .o_oe_n   (o_oe_n_w)
   );
   // the sub-block registers its pins already; this stage keeps all outputs registered
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_addr <= 20'h00000; o_dq_out <= 8'h00; o_dq_oe <= 1'b0;
         o_ce_n <= 1'b1; o_we_n <= 1'b1; o_oe_n <= 1'b1; o_reset_n <= 1'b1;
      end else begin
         o_addr <= o_addr_w; o_dq_out <= o_dq_out_w; o_dq_oe <= o_dq_oe_w;
         o_ce_n <= o_ce_n_w; o_we_n <= o_we_n_w; o_oe_n <= o_oe_n_w;
         o_reset_n <= (next_state != FS_HWRST);
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_window_close: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == FS_WINDOW && win_out && !accept) |=> (state == FS_POLL))
      else $error("load window did not close into polling");
   chk_suspend_gate: assert property (@(posedge i_clock) disable iff (i_rst)
      (accept && cmd_op == OP_SUSPEND) |-> erasing && !suspended)
      else $error("suspend accepted without running erase");
   chk_resume_gate: assert property (@(posedge i_clock) disable iff (i_rst)
      (accept && cmd_op == OP_RESUME) |=> !suspended)
      else $error("resume did not clear suspend");
   chk_prog_ignore: assert property (@(posedge i_clock) disable iff (i_rst)
      (cmd_wr && in_prog && cmd_op != OP_HWRESET) |=> refused)
      else $error("order during programming not refused");
   chk_we_pins: assert property (@(posedge i_clock) disable iff (i_rst)
      $fell(o_we_n) |-> !o_ce_n && o_dq_oe && o_oe_n)
      else $error("write strobe without select and data");
   chk_hw_reset: assert property (@(posedge i_clock) disable iff (i_rst)
      (accept && cmd_op == OP_HWRESET) |=> !o_reset_n)
      else $error("hardware reset pin not pulsed");
   chk_done_pair: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == FS_POLL && next_state == FS_FINAL) |-> !first_poll && tog_now == prev_toggle)
      else $error("completion without two equal toggle reads");
   chk_susp_time: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == FS_SUSP) |-> ##[0:850] (state != FS_SUSP))
      else $error("suspend wait too long");
endmodule

// ### testbench/fesq_flash_model.sv
// behavioural flash partner: program command sequence, polling status, ready/busy
// assumes one program location; clock only samples the asynchronous strobes
`timescale 1ns/100ps
module fesq_flash_model
   import fesq_pkg::*;
(
   input  wire logic        i_clock, // sampling clock
   input  wire logic [19:0] i_addr,  // address pins
   input  wire logic [7:0]  i_dq,    // data from controller
   input  wire logic        i_ce_n,  // chip select
   input  wire logic        i_we_n,  // write strobe
   input  wire logic        i_oe_n,  // output enable
   input  wire logic        i_reset_n, // hardware reset pin
   output logic [7:0]       o_dq,    // data to controller
   output logic             o_rb_n,  // pulled-up ready/busy line
   output logic [7:0]       o_last   // stored byte
);
   logic [1:0]  step = 2'h0;
   logic [3:0]  busy = 4'h0;
   logic        tog  = 1'b0;
   logic        we_q = 1'b1;
   logic        oe_q = 1'b1;
   logic [19:0] wa   = 20'h00000;
   logic [7:0]  wd   = 8'h00;
   initial o_last = 8'hFF;
   initial o_dq = 8'h00;
   // open drain: low only while busy, else the pull-up wins
   assign o_rb_n = (busy == 4'h0);
   // address held while low, command taken at the rising strobe
   always @(posedge i_clock) begin
      we_q <= i_we_n;
      oe_q <= i_oe_n;
      if (!i_we_n && !i_ce_n) begin
         wa <= i_addr;
         wd <= i_dq;
      end
      // writes while programming are dropped
      if (!we_q && i_we_n && busy == 4'h0) begin
         if (step == 2'h0) step <= (wa == UNLOCK_ADDR1 && wd == UNLOCK_DATA1) ? 2'h1 : 2'h0;
         if (step == 2'h1) step <= (wa == UNLOCK_ADDR2 && wd == UNLOCK_DATA2) ? 2'h2 : 2'h0;
         if (step == 2'h2) step <= (wd == CMD_PROG_SETUP) ? 2'h3 : 2'h0;
         if (step == 2'h3) begin
            o_last <= o_last & wd;
            busy <= 4'h6;
            step <= 2'h0;
         end
      end
      // each read while busy flips the toggle bit
      if (oe_q && !i_oe_n && busy != 4'h0) begin
         busy <= busy - 4'h1;
         tog <= ~tog;
      end
      // released bus inverts every cycle, so the last driven value returns every other cycle
      o_dq <= i_oe_n ? ~o_dq : (busy != 4'h0) ? {~o_last[7], tog, 6'h00} : o_last;
      // the reset pin abandons a half-sent sequence and a running program
      if (!i_reset_n) begin
         step <= 2'h0;
         busy <= 4'h0;
      end
   end
endmodule

// ### testbench/tb_top.sv
// bench for the flash controller: register tasks, a program run, a refused op
// assumes the flash model on the pins and the plain register port
`timescale 1ns/100ps
module tb_top
   import fesq_pkg::*;
;
   logic        i_clock = 1'b0;
   logic        i_rst   = 1'b1;
   logic [3:0]  ra = 4'h0;
   logic [31:0] wd = 32'h00000000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata, st;
   logic [7:0]  dq_in, dq_out, last;
   logic [19:0] addr;
   logic        rb_n, oe, ce_n, we_n, oe_n, seen, rst_n;
   int          n_errors = 0;
   int          comparisons = 0;
   initial forever #12.5 i_clock = ~i_clock;
   fesq_ctrl dut (.i_clock(i_clock), .i_rst(i_rst), .i_reg_addr(ra), .i_reg_wdata(wd),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_dq_in(dq_in),
      .i_ready_busy_n(rb_n), .o_addr(addr), .o_dq_out(dq_out), .o_dq_oe(oe), .o_ce_n(ce_n),
      .o_we_n(we_n), .o_oe_n(oe_n), .o_reset_n(rst_n));
   fesq_flash_model flash (.i_clock(i_clock), .i_addr(addr), .i_dq(dq_out), .i_ce_n(ce_n),
      .i_we_n(we_n), .i_oe_n(oe_n), .i_reset_n(rst_n), .o_dq(dq_in), .o_rb_n(rb_n),
      .o_last(last));
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clock) begin ra <= a; wd <= d; wr <= 1'b1; end
      @(posedge i_clock) wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_clock) begin ra <= a; rd <= 1'b1; end
      @(posedge i_clock) rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // bounded poll of one status bit; a lapse counts as a mismatch and ends the run
   task automatic wait_bit(input int b);
      seen = 1'b0;
      st   = RST_ZERO;
      for (int i = 0; i < 3000 && st[b] !== 1'b1; i++) begin
         rd_reg(REG_STATUS, st);
         seen |= !st[10];
      end
      if (st[b] !== 1'b1) begin
         n_errors++;
         summarize();
      end
   endtask
   // suspend when idle is refused, then a program with orders thrown at it while it runs
   initial begin
      repeat (10) @(posedge i_clock);
      i_rst <= 1'b0;
      wr_reg(REG_CMD, {29'h0, OP_SUSPEND});
      rd_reg(REG_STATUS, st);
      check(st[7], 1'b1);
      wr_reg(REG_ADDR, 32'h00012345);
      wr_reg(REG_DATA, 32'h0000005A);
      wr_reg(REG_CMD, {29'h0, OP_PROGRAM});
      wr_reg(REG_CMD, {29'h0, OP_ERASE});
      wr_reg(REG_ADDR, 32'h00054321);
      wait_bit(5);
      check(seen, 1'b1);
      check(st[7], 1'b1);
      check(last, 8'h5A);
      check(rb_n, 1'b1);
      rd_reg(REG_ADDR, st);
      check(st, 32'h00012345);
      rd_reg(REG_RDDATA, st);
      check(st[7:0], 8'h5A);
      rd_reg(4'hF, st);
      check(st, RST_ZERO);
      // erase suspended inside the load window, then resumed and run to the end
      wr_reg(REG_ADDR, 32'h00010000);
      wr_reg(REG_CMD, {29'h0, OP_ERASE});
      repeat (100) @(posedge i_clock);
      wr_reg(REG_CMD, {29'h0, OP_SUSPEND});
      wait_bit(8);
      check(st[9], 1'b1);
      check(st[4], 1'b0);
      wr_reg(REG_CMD, {29'h0, OP_RESUME});
      wait_bit(5);
      check(st[9:8], 2'b00);
      // second erase: a stray resume is refused, a sector is added, the window lapses
      wr_reg(REG_ADDR, 32'h00020000);
      wr_reg(REG_CMD, {29'h0, OP_ERASE});
      repeat (100) @(posedge i_clock);
      wr_reg(REG_CMD, {29'h0, OP_RESUME});
      rd_reg(REG_STATUS, st);
      check(st[7], 1'b1);
      wr_reg(REG_ADDR, 32'h00030000);
      wr_reg(REG_CMD, {29'h0, OP_ADD_SECT});
      rd_reg(REG_STATUS, st);
      check(st[7], 1'b0);
      wait_bit(5);
      check(st[9], 1'b0);
      // hardware reset cuts a program short, which is then issued again
      wr_reg(REG_ADDR, 32'h00012345);
      wr_reg(REG_DATA, 32'h0000000F);
      wr_reg(REG_CMD, {29'h0, OP_PROGRAM});
      wr_reg(REG_CMD, {29'h0, OP_HWRESET});
      @(negedge i_clock) check(rst_n, 1'b0);
      repeat (40) @(posedge i_clock);
      check(rst_n, 1'b1);
      wr_reg(REG_CMD, {29'h0, OP_PROGRAM});
      wait_bit(5);
      check(last, 8'h0A);
      summarize();
   end
endmodule
